// >>> hw/csb_pkg.sv
package csb_pkg;
	// ---------------------------------------------------------------
	// operation codes and widths
	// ---------------------------------------------------------------
	localparam int PC_W    = 16;
	localparam int OFS_W   = 7;
	localparam int FLAG_C  = 0;
	localparam int FLAG_Z  = 1;
	localparam int FLAG_N  = 2;
	localparam int FLAG_V  = 3;
	localparam int FLAG_S  = 4;
	localparam int FLAG_H  = 5;
	localparam logic [PC_W-1:0] PC_RESET   = 16'h0000;
	localparam logic [PC_W-1:0] STEP_ONE   = 16'h0001;
	localparam logic [PC_W-1:0] SKIP_SHORT = 16'h0002;
	localparam logic [PC_W-1:0] SKIP_LONG  = 16'h0003;
	localparam logic [1:0]      CYC_ONE    = 2'h1;
	localparam logic [1:0]      CYC_TWO    = 2'h2;
	localparam logic [1:0]      CYC_THREE  = 2'h3;

	typedef enum logic [3:0] {
		OP_NONE,
		OP_COMPARE_WITH_IMMEDIATE,
		OP_SKIP_REG_BIT_CLEAR,
		OP_SKIP_REG_BIT_SET,
		OP_SKIP_IO_BIT_CLEAR,
		OP_SKIP_IO_BIT_SET,
		OP_BRANCH_FLAG_SET,
		OP_BRANCH_FLAG_CLEAR,
		OP_BRANCH_NO_CARRY,
		OP_BRANCH_UNSIGNED_GE,
		OP_BRANCH_SIGNED_GE
	} op_t;

	typedef struct packed {
		op_t              op;
		logic [7:0]       reg_val;
		logic [7:0]       imm;
		logic [7:0]       io_val;
		logic [2:0]       bit_sel;
		logic [OFS_W-1:0] offset;
		logic             next_is_long;
	} instr_t;

	typedef struct packed {
		logic [PC_W-1:0] pc;
		logic [7:0]      flags;
		logic [1:0]      cycles;
	} result_t;
endpackage : csb_pkg

// >>> hw/compare_flags.sv
module compare_flags
	import csb_pkg::*;
(
	input  wire logic [7:0] i_a,
	input  wire logic [7:0] i_b,
	input  wire logic [7:0] i_flags,
	output logic      [7:0] o_flags
);
	logic [8:0] diff;
	logic       n_bit;
	logic       v_bit;
	logic       h_bit;
	assign diff  = {1'b0, i_a} - {1'b0, i_b};
	assign n_bit = diff[7];
	assign v_bit = (i_a[7] & ~i_b[7] & ~diff[7]) | (~i_a[7] & i_b[7] & diff[7]);
	assign h_bit = (~i_a[3] & i_b[3]) | (i_b[3] & diff[3]) | (diff[3] & ~i_a[3]);

	always_comb begin
		o_flags         = i_flags;
		o_flags[FLAG_C] = diff[8];
		o_flags[FLAG_Z] = (diff[7:0] == 8'h00);
		o_flags[FLAG_N] = n_bit;
		o_flags[FLAG_V] = v_bit;
		o_flags[FLAG_S] = n_bit ^ v_bit;
		o_flags[FLAG_H] = h_bit;
	end
endmodule : compare_flags

// >>> hw/compare_skip_branch_unit.sv
// How it works
// RULE1 - compare immediate: subtract, discard result, update Z N V C H, one cycle
// RULE2 - register bit clear skips two or three words; flags kept; one to three cycles
// RULE3 - register bit set skips two or three words; flags unchanged
// RULE4 - I/O bit clear skips two or three words, one to three cycles
// RULE5 - I/O bit set skips; otherwise next instruction; flags unchanged
// RULE6 - flag set branch: pc plus offset plus one; one or two cycles
// RULE7 - flag clear branch to pc plus offset plus one; flags untouched
// RULE8 - no-carry branch only when carry zero; two cycles taken, one not
// RULE9 - unsigned greater-or-equal branch taken when carry is zero
// RULE10 - signed greater-or-equal branch taken when N xor V is zero
// RULE11 - skip of one-word instruction adds two, two-word adds three, cycle per word
module compare_skip_branch_unit
(
	input  wire logic                 i_core_clk,
	input  wire logic                 i_reset_n,
	input  wire logic                 i_valid,
	input  wire csb_pkg::instr_t      i_instr,
	input  wire logic [csb_pkg::PC_W-1:0] i_pc,
	input  wire logic [7:0]           i_flags,
	output logic                      o_ready,
	output logic                      o_done,
	output csb_pkg::result_t          o_result
);
	import csb_pkg::*;

	typedef enum {ST_IDLE, ST_BUSY} state_t;

	// ---------------------------------------------------------------
	// decode
	// ---------------------------------------------------------------
	logic [7:0]      cmp_flags;
	logic            reg_bit;
	logic            io_bit;
	logic            flag_bit;
	logic            skip_hit;
	logic            branch_hit;
	logic [PC_W-1:0] skip_len;
	logic [PC_W-1:0] ofs_ext;
	logic [PC_W-1:0] pc_skip;
	logic [PC_W-1:0] pc_branch;
	logic [PC_W-1:0] pc_plain;
	logic            is_cmp;
	logic            accept;

	compare_flags u_cmp (
		.i_a     (i_instr.reg_val),
		.i_b     (i_instr.imm),
		.i_flags (i_flags),
		.o_flags (cmp_flags)
	);

	assign reg_bit  = i_instr.reg_val[i_instr.bit_sel];
	assign io_bit   = i_instr.io_val[i_instr.bit_sel];
	assign flag_bit = i_flags[i_instr.bit_sel];
	assign is_cmp   = (i_instr.op == OP_COMPARE_WITH_IMMEDIATE); // RULE1

	assign skip_hit =
		((i_instr.op == OP_SKIP_REG_BIT_CLEAR) & ~reg_bit) | // RULE2
		((i_instr.op == OP_SKIP_REG_BIT_SET)   &  reg_bit) | // RULE3
		((i_instr.op == OP_SKIP_IO_BIT_CLEAR)  & ~io_bit)  | // RULE4
		((i_instr.op == OP_SKIP_IO_BIT_SET)    &  io_bit);   // RULE5

	assign branch_hit =
		((i_instr.op == OP_BRANCH_FLAG_SET)    &  flag_bit) |       // RULE6
		((i_instr.op == OP_BRANCH_FLAG_CLEAR)  & ~flag_bit) |       // RULE7
		((i_instr.op == OP_BRANCH_NO_CARRY)    & ~i_flags[FLAG_C]) | // RULE8
		((i_instr.op == OP_BRANCH_UNSIGNED_GE) & ~i_flags[FLAG_C]) | // RULE9
		((i_instr.op == OP_BRANCH_SIGNED_GE)   &
			~(i_flags[FLAG_N] ^ i_flags[FLAG_V]));                    // RULE10

	// skipped length follows the word count of the instruction after it
	assign skip_len  = i_instr.next_is_long ? SKIP_LONG : SKIP_SHORT; // RULE11
	assign ofs_ext   = {{(PC_W-OFS_W){i_instr.offset[OFS_W-1]}}, i_instr.offset};
	assign pc_skip   = i_pc + skip_len;                       // RULE2 RULE3 RULE4 RULE5
	assign pc_branch = i_pc + ofs_ext + STEP_ONE;             // RULE6 RULE7 RULE10
	assign pc_plain  = i_pc + STEP_ONE;

	// ---------------------------------------------------------------
	// result selection
	// ---------------------------------------------------------------
	result_t res_nxt;
	always_comb begin
		res_nxt.flags  = is_cmp ? cmp_flags : i_flags; // RULE1
		res_nxt.pc     = pc_plain;
		res_nxt.cycles = CYC_ONE;
		if (skip_hit) begin
			res_nxt.pc     = pc_skip;
			res_nxt.cycles = i_instr.next_is_long ? CYC_THREE : CYC_TWO; // RULE11
		end else if (branch_hit) begin
			res_nxt.pc     = pc_branch;
			res_nxt.cycles = CYC_TWO; // RULE8
		end
	end

	// ---------------------------------------------------------------
	// cycle sequencer
	// ---------------------------------------------------------------
	// done fires at the end of the last cycle, so a taken branch costs a stall
	state_t     state_r;
	state_t     state_nxt;
	result_t    result_r;
	logic [1:0] left_r;
	logic [1:0] left_nxt;
	logic       done_r;
	logic       done_nxt;

	assign o_ready = (state_r == ST_IDLE);
	assign accept  = o_ready & i_valid & (i_instr.op != OP_NONE);

	always_comb begin
		state_nxt = state_r;
		left_nxt  = left_r;
		done_nxt  = 1'b0;
		case (state_r)
			ST_IDLE: begin
				if (accept) begin
					if (res_nxt.cycles == CYC_ONE) begin
						done_nxt = 1'b1;
					end else begin
						state_nxt = ST_BUSY;
						left_nxt  = res_nxt.cycles - CYC_ONE;
					end
				end
			end
			ST_BUSY: begin
				left_nxt = left_r - CYC_ONE;
				if (left_r == CYC_ONE) begin
					state_nxt = ST_IDLE;
					done_nxt  = 1'b1;
				end
			end
			default: state_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_r  <= ST_IDLE;
			left_r   <= 2'h0;
			done_r   <= 1'b0;
			result_r <= '0;
		end else begin
			state_r <= state_nxt;
			left_r  <= left_nxt;
			done_r  <= done_nxt;
			if (accept) begin
				result_r <= res_nxt;
			end
		end
	end

	assign o_done   = done_r;
	assign o_result = result_r;
endmodule : compare_skip_branch_unit

// >>> tb/csb_properties.sv
module csb_properties
	import csb_pkg::*;
(
	input wire logic            i_core_clk,
	input wire logic            i_reset_n,
	input wire logic            i_valid,
	input wire instr_t          i_instr,
	input wire logic [PC_W-1:0] i_pc,
	input wire logic [7:0]      i_flags,
	input wire logic            o_ready,
	input wire logic            o_done,
	input wire result_t         o_result
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_reset_n);
	op_t  op;
	logic a, rb, ib, fb;
	assign op = i_instr.op;
	assign a  = o_ready & i_valid & (op != OP_NONE);
	assign rb = i_instr.reg_val[i_instr.bit_sel];
	assign ib = i_instr.io_val[i_instr.bit_sel];
	assign fb = i_flags[i_instr.bit_sel];
	cmp_fast_a: assert property (a && op == OP_COMPARE_WITH_IMMEDIATE |=> o_done)
		else $error("slow compare");
	long_skip_a: assert property (a && op == OP_SKIP_REG_BIT_CLEAR && !rb
		&& i_instr.next_is_long |=> !o_done[*2] ##1 o_done) else $error("long skip");
	short_skip_a: assert property (a && op == OP_SKIP_REG_BIT_SET && rb
		&& !i_instr.next_is_long |=> !o_done ##1 o_done) else $error("short skip");
	io_skip_a: assert property (a && op == OP_SKIP_IO_BIT_CLEAR && !ib
		|=> o_result.pc == $past(i_pc) + ($past(i_instr.next_is_long) ? SKIP_LONG : SKIP_SHORT))
		else $error("io skip");
	flag_take_a: assert property (a && op == OP_BRANCH_FLAG_SET && fb
		|=> !o_done ##1 o_done) else $error("flag branch");
	flags_kept_a: assert property (a && op == OP_BRANCH_FLAG_CLEAR
		|=> o_result.flags == $past(i_flags)) else $error("flags changed");
	carry_hold_a: assert property (a && op == OP_BRANCH_NO_CARRY && i_flags[FLAG_C]
		|=> o_done && o_result.pc == $past(i_pc) + STEP_ONE) else $error("carry taken");
	signed_ge_a: assert property (a && op == OP_BRANCH_SIGNED_GE
		&& !(i_flags[FLAG_N] ^ i_flags[FLAG_V]) |=> o_result.cycles == CYC_TWO) else $error("sge");
	flag_c: cover property (a && op == OP_BRANCH_FLAG_SET);
	skip_c: cover property (o_done && o_result.cycles == CYC_THREE);
	cmp_c: cover property (a && op == OP_COMPARE_WITH_IMMEDIATE);
endmodule : csb_properties
bind compare_skip_branch_unit csb_properties chk_u (.i_core_clk, .i_reset_n, .i_valid, .i_instr,
	.i_pc, .i_flags, .o_ready, .o_done, .o_result);

// >>> tb/tb.sv
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import csb_pkg::*;
	`define CHK(x, y) begin num_checks++; if ((x) !== (y)) begin n_errors++; \
		$display("Error %0t %h %h", $time, x, y); end end
	logic       i_core_clk = 1'b0, i_reset_n = 1'b0, i_valid = 1'b0, o_ready, o_done;
	logic [7:0] i_flags = 8'h00;
	instr_t     i_instr = '0;
	logic [PC_W-1:0] i_pc = 16'h0080;
	result_t    o_result;
	int         n_errors = 0, num_checks = 0, cyc = 0;
	always #20 i_core_clk = ~i_core_clk;
	compare_skip_branch_unit dut_u (.i_core_clk, .i_reset_n, .i_valid, .i_instr, .i_pc,
		.i_flags, .o_ready, .o_done, .o_result);
	// some 17 operations of at most five cycles each
	always @(posedge i_core_clk) begin
		cyc++;
		if (cyc == 600) begin
			n_errors++;
			results();
		end
	end
	task automatic results;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : results
	// e is the expected pc low byte; offset of minus two lands a taken branch on 7F
	task automatic run(op_t op, logic [7:0] f, e, r = 8'h08, ef = 8'h00);
		int         k;
		logic [1:0] c;
		logic [7:0] xf;
		c  = (e == 8'h81) ? 2'h1 : ((e == 8'h7F) ? 2'h2 : e[1:0]);
		xf = (op == OP_COMPARE_WITH_IMMEDIATE) ? ef : f;
		@(posedge i_core_clk);
		i_instr <= '{op, r, 8'h05, r, 3'h3, 7'h7E, e == 8'h83};
		i_flags <= f;
		i_valid <= 1'b1;
		@(posedge i_core_clk);
		i_valid <= 1'b0;
		k = 0;
		do begin
			@(negedge i_core_clk);
			k++;
		end while (o_done !== 1'b1 && k < 4);
		`CHK(o_result.pc, {i_pc[15:8], e})
		`CHK(o_result.flags, xf)
		`CHK(o_result.cycles, c)
		`CHK(k, int'(c))
		`CHK(o_ready, 1'b1)
	endtask : run
	task automatic t_compare;
		run(OP_COMPARE_WITH_IMMEDIATE, 8'hC0, 8'h81, 8'h05, 8'hC2);
		run(OP_COMPARE_WITH_IMMEDIATE, 8'h00, 8'h81, 8'h80, 8'h38);
		$display("compare test done");
	endtask : t_compare
	task automatic t_skip;
		run(OP_SKIP_REG_BIT_CLEAR, 8'hA5, 8'h83, 8'hF7);
		run(OP_SKIP_REG_BIT_SET, 8'hA5, 8'h82);
		run(OP_SKIP_IO_BIT_CLEAR, 8'hA5, 8'h82, 8'hF7);
		run(OP_SKIP_IO_BIT_SET, 8'hA5, 8'h81, 8'hF7);
		run(OP_SKIP_IO_BIT_SET, 8'hA5, 8'h83);
		$display("skip test done");
	endtask : t_skip
	task automatic t_branch;
		@(posedge i_core_clk);
		i_pc <= 16'h3C80;
		run(OP_BRANCH_FLAG_SET, 8'h08, 8'h7F);
		run(OP_BRANCH_FLAG_CLEAR, 8'hF7, 8'h7F);
		run(OP_BRANCH_NO_CARRY, 8'h01, 8'h81);
		run(OP_BRANCH_NO_CARRY, 8'hFE, 8'h7F);
		run(OP_BRANCH_UNSIGNED_GE, 8'hFE, 8'h7F);
		run(OP_BRANCH_SIGNED_GE, 8'h0C, 8'h7F);
		run(OP_BRANCH_SIGNED_GE, 8'h04, 8'h81);
		$display("branch test done");
	endtask : t_branch
	// an empty op must neither start work nor disturb the standing result
	task automatic t_refuse;
		@(posedge i_core_clk);
		i_instr.op <= OP_NONE;
		i_valid    <= 1'b1;
		@(posedge i_core_clk);
		i_valid <= 1'b0;
		repeat (3) begin
			@(negedge i_core_clk);
			`CHK({o_ready, o_done}, 2'b10)
		end
		`CHK(o_result.pc, {i_pc[15:8], 8'h81})
		$display("refuse test done");
	endtask : t_refuse
	// reset lands in the middle of a three-cycle skip
	task automatic t_reset;
		@(posedge i_core_clk);
		i_instr <= '{OP_SKIP_REG_BIT_CLEAR, 8'hF7, 8'h05, 8'hF7, 3'h3, 7'h7E, 1'b1};
		i_valid <= 1'b1;
		@(posedge i_core_clk);
		i_valid <= 1'b0;
		@(negedge i_core_clk);
		`CHK({o_ready, o_done}, 2'b00)
		@(posedge i_core_clk);
		i_reset_n <= 1'b0;
		@(negedge i_core_clk);
		`CHK({o_ready, o_done}, 2'b10)
		`CHK(o_result, result_t'(0))
		repeat (2) @(posedge i_core_clk);
		i_reset_n <= 1'b1;
		run(OP_SKIP_REG_BIT_CLEAR, 8'hA5, 8'h83, 8'hF7);
		$display("reset test done");
	endtask : t_reset
	initial begin
		repeat (16) @(posedge i_core_clk);
		i_reset_n <= 1'b1;
		t_compare();
		t_skip();
		t_branch();
		t_refuse();
		t_reset();
		results();
	end
endmodule : tb
